// ### fpec_pkg.sv
package fpec_pkg;
    // Command opcodes
    localparam logic [7:0] OP_PROG_BUF1 = 8'h88;
    localparam logic [7:0] OP_PROG_BUF2 = 8'h89;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
    // Frame layout: opcode plus three address bytes
    localparam int FRAME_BITS = 32;
    localparam int ADDR_BITS = 24;
    localparam int PAGE_BITS = 13;
    // Page field position in the 24-bit address, per page size
    localparam int PAGE_LSB_528 = 10;
    localparam int PAGE_LSB_512 = 9;
    // Block and sector fields inside the page number
    localparam int BLOCK_LSB = 3;
    localparam int SECTOR_LSB = 7;
    localparam int SECTOR_BITS = 6;
    localparam int PAGES_PER_BLOCK = 8;
    // Self-timed operation limits in microseconds
    localparam int CLK_MHZ = 50;
    localparam int PROG_TIME_US = 4000;
    localparam int PAGE_ERASE_TIME_US = 35000;
    localparam int BLOCK_ERASE_TIME_US = 100000;
    localparam int SECTOR_ERASE_TIME_US = 5000000;
    localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
    localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam longint SECTOR_ERASE_CYC = 64'(SECTOR_ERASE_TIME_US) * 64'(CLK_MHZ);
    // Host link clock divider: half period in clk cycles
    localparam int SCK_HALF_CYC = 4;
    // Operation kinds
    typedef enum logic [4:0] {
        FPEC_OP_NONE = 5'h01,
        FPEC_OP_PROG = 5'h02,
        FPEC_OP_PERASE = 5'h04,
        FPEC_OP_BERASE = 5'h08,
        FPEC_OP_SERASE = 5'h10
    } fpec_op_t;
endpackage

// ### fpec_link_if.sv
interface fpec_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic rdy_busy_n;
    modport device (input cs_n, input sck, input si, output rdy_busy_n);
    modport host (output cs_n, output sck, output si, input rdy_busy_n);
endinterface

// ### fpec_device.sv
module fpec_device #(
    parameter int PROG_CYCLES = fpec_pkg::PROG_CYC,
    parameter int PAGE_ERASE_CYCLES = fpec_pkg::PAGE_ERASE_CYC,
    parameter int BLOCK_ERASE_CYCLES = fpec_pkg::BLOCK_ERASE_CYC,
    parameter longint SECTOR_ERASE_CYCLES = fpec_pkg::SECTOR_ERASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    fpec_link_if.device link,
    input wire logic page_size_512,
    output logic status_busy,
    output logic op_start,
    output fpec_pkg::fpec_op_t op_kind,
    output logic op_buffer_sel,
    output logic [12:0] op_first_page,
    output logic [3:0] op_page_count,
    output logic [5:0] op_sector,
    output logic op_sector_0b,
    output logic op_done
);
    // Synchronised pins and edge history
    logic [1:0] cs_sync_ff, sck_sync_ff, si_sync_ff;
    logic cs_n_ff, sck_ff;
    // Frame shift register and bit count
    logic [31:0] shift_ff;
    logic [5:0] bit_cnt_ff;
    // Self-timed busy state
    logic busy_ff;
    logic [39:0] timer_ff;
    logic [39:0] nxt_timer;
    // Captured operation fields
    fpec_pkg::fpec_op_t kind_ff;
    logic buf_ff, sec0b_ff, start_ff, done_ff;
    logic [12:0] page_ff;
    logic [3:0] count_ff;
    logic [5:0] sector_ff;
    logic sck_rise, cs_rise, cs_low;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [12:0] page_num;
    fpec_pkg::fpec_op_t nxt_kind;
    logic launch;

    // Two-stage synchronisers for link pins
    // Reset values equal idle pin levels, so no false edge after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_sync_ff <= 2'h3;
            sck_sync_ff <= 2'h0;
            si_sync_ff <= 2'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
            sck_sync_ff <= {sck_sync_ff[0], link.sck};
            si_sync_ff <= {si_sync_ff[0], link.si};
        end
    end

    // Edge history taken from the second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_ff <= 1'b1;
            sck_ff <= 1'b0;
        end else begin
            cs_n_ff <= cs_sync_ff[1];
            sck_ff <= sck_sync_ff[1];
        end
    end

    assign sck_rise = sck_sync_ff[1] & ~sck_ff;
    assign cs_rise = cs_sync_ff[1] & ~cs_n_ff;
    assign cs_low = ~cs_sync_ff[1];

    // Shift in opcode and address MSB first while selected
    // Bits past the 32nd are not kept; the count saturates there
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_ff <= 32'h0;
            bit_cnt_ff <= 6'h0;
        end else if (!cs_low) begin
            bit_cnt_ff <= 6'h0;
        end else if (sck_rise && bit_cnt_ff != 6'(fpec_pkg::FRAME_BITS)) begin
            shift_ff <= {shift_ff[30:0], si_sync_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 6'h1;
        end
    end

    assign opcode = shift_ff[31:24];
    assign addr = shift_ff[23:0];

    // Page number extraction per page size
    // 528 layout skips one top bit, 512 layout skips two
    always_comb begin
        if (page_size_512) begin
            page_num = addr[fpec_pkg::PAGE_LSB_512 +: fpec_pkg::PAGE_BITS];
        end else begin
            page_num = addr[fpec_pkg::PAGE_LSB_528 +: fpec_pkg::PAGE_BITS];
        end
    end

    // Opcode decode
    always_comb begin
        unique case (opcode)
            fpec_pkg::OP_PROG_BUF1, fpec_pkg::OP_PROG_BUF2: nxt_kind = fpec_pkg::FPEC_OP_PROG;
            fpec_pkg::OP_PAGE_ERASE: nxt_kind = fpec_pkg::FPEC_OP_PERASE;
            fpec_pkg::OP_BLOCK_ERASE: nxt_kind = fpec_pkg::FPEC_OP_BERASE;
            fpec_pkg::OP_SECTOR_ERASE: nxt_kind = fpec_pkg::FPEC_OP_SERASE;
            default: nxt_kind = fpec_pkg::FPEC_OP_NONE;
        endcase
    end

    // Frame accepted: 32 bits or more (count saturates at 32), known opcode, not busy
    assign launch = cs_rise && !busy_ff && bit_cnt_ff == 6'(fpec_pkg::FRAME_BITS)
        && nxt_kind != fpec_pkg::FPEC_OP_NONE;

    // Launch on chip select rise after a full frame; ignore while busy
    always_ff @(posedge clk) begin
        if (rst) begin
            kind_ff <= fpec_pkg::FPEC_OP_NONE;
            buf_ff <= 1'b0;
            page_ff <= 13'h0;
            count_ff <= 4'h0;
            sector_ff <= 6'h0;
            sec0b_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (launch) begin
                kind_ff <= nxt_kind;
                start_ff <= 1'b1;
                buf_ff <= opcode[0];
                page_ff <= page_num;
                count_ff <= 4'h1;
                // Sector fields kept for every command; only sector erase uses them
                sector_ff <= page_num[fpec_pkg::SECTOR_LSB +: fpec_pkg::SECTOR_BITS];
                sec0b_ff <= page_num[fpec_pkg::BLOCK_LSB];
                if (nxt_kind == fpec_pkg::FPEC_OP_BERASE) begin
                    // Low three page bits ignored: block of eight
                    page_ff <= {page_num[12:3], 3'h0};
                    count_ff <= 4'(fpec_pkg::PAGES_PER_BLOCK);
                end
            end
        end
    end

    // Self-timed counter for the selected operation
    // Timer is 40 bits so the longest erase at default timing fits
    always_comb begin
        unique case (nxt_kind)
            fpec_pkg::FPEC_OP_PROG: nxt_timer = 40'(PROG_CYCLES);
            fpec_pkg::FPEC_OP_PERASE: nxt_timer = 40'(PAGE_ERASE_CYCLES);
            fpec_pkg::FPEC_OP_BERASE: nxt_timer = 40'(BLOCK_ERASE_CYCLES);
            fpec_pkg::FPEC_OP_SERASE: nxt_timer = 40'(SECTOR_ERASE_CYCLES);
            default: nxt_timer = 40'h1;
        endcase
    end

    // Busy from launch until the timer expires
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            timer_ff <= 40'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            // Frames that end while busy are dropped, not queued
            if (launch) begin
                busy_ff <= 1'b1;
                timer_ff <= nxt_timer;
            end else if (busy_ff) begin
                // Last count clears busy and pulses done
                if (timer_ff == 40'h1) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                timer_ff <= timer_ff - 40'h1;
            end
        end
    end

    // Outputs toward the array and the status register
    assign link.rdy_busy_n = ~busy_ff;
    assign status_busy = busy_ff; // Status register busy bit mirrors the pin
    assign op_start = start_ff;
    assign op_kind = kind_ff;
    assign op_buffer_sel = buf_ff;
    assign op_first_page = page_ff;
    assign op_page_count = count_ff;
    assign op_sector = sector_ff;
    assign op_sector_0b = sec0b_ff;
    assign op_done = done_ff;
endmodule

// ### fpec_host.sv
// Host end: sends opcode and three address bytes, MSB first, mode 0
module fpec_host (
    input wire logic clk,
    input wire logic rst,
    fpec_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [23:0] cmd_addr,
    output logic dev_ready
);
    typedef enum logic [2:0] {
        FPEC_H_IDLE = 3'h1,
        FPEC_H_SHIFT = 3'h2,
        FPEC_H_END = 3'h4
    } fpec_hstate_t;
    fpec_hstate_t state_ff;
    logic [31:0] shift_ff;
    logic [5:0] bit_cnt_ff;
    logic [3:0] div_ff;
    logic sck_ff, cs_n_ff;
    logic [1:0] rdy_sync_ff;

    // Ready pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_sync_ff <= 2'h0;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[0], link.rdy_busy_n};
        end
    end

    // Frame sequencer with clock divider; erase-before-program is caller's duty
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= FPEC_H_IDLE;
            shift_ff <= 32'h0;
            bit_cnt_ff <= 6'h0;
            div_ff <= 4'h0;
            sck_ff <= 1'b0;
            cs_n_ff <= 1'b1;
        end else begin
            unique case (state_ff)
                FPEC_H_IDLE: begin
                    if (cmd_valid && rdy_sync_ff[1]) begin
                        shift_ff <= {cmd_opcode, cmd_addr};
                        cs_n_ff <= 1'b0;
                        bit_cnt_ff <= 6'h0;
                        div_ff <= 4'h0;
                        state_ff <= FPEC_H_SHIFT;
                    end
                end
                FPEC_H_SHIFT: begin
                    if (div_ff == 4'(fpec_pkg::SCK_HALF_CYC - 1)) begin
                        div_ff <= 4'h0;
                        sck_ff <= ~sck_ff;
                        if (sck_ff) begin
                            shift_ff <= {shift_ff[30:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 6'h1;
                            if (bit_cnt_ff == 6'(fpec_pkg::FRAME_BITS - 1)) begin
                                state_ff <= FPEC_H_END;
                            end
                        end
                    end else begin
                        div_ff <= div_ff + 4'h1;
                    end
                end
                FPEC_H_END: begin
                    div_ff <= div_ff + 4'h1;
                    if (div_ff == 4'(fpec_pkg::SCK_HALF_CYC - 1)) begin
                        cs_n_ff <= 1'b1;
                    end
                    // Stay out of idle until the device's busy has crossed back
                    if (div_ff == 4'(3 * fpec_pkg::SCK_HALF_CYC)) begin
                        state_ff <= FPEC_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sck = sck_ff;
    assign link.si = shift_ff[31];
    assign cmd_ready = (state_ff == FPEC_H_IDLE) && rdy_sync_ff[1];
    assign dev_ready = rdy_sync_ff[1];
endmodule

// ### fpec_link_properties.sv
module fpec_link_properties #(
    parameter int PROG_CYCLES = 20,
    parameter int PAGE_ERASE_CYCLES = 30,
    parameter int BLOCK_ERASE_CYCLES = 40,
    parameter longint SECTOR_ERASE_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic rdy_busy_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q_ff;
    logic cs_q_ff;
    logic [5:0] bits_ff;
    logic [7:0] op_ff;
    longint busy_cnt_ff;
    longint want;
    logic sck_rise;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Link clock edge seen from clk
    assign sck_rise = sck && !sck_q_ff;
    always_ff @(posedge clk) begin
        sck_q_ff <= rst ? 1'b0 : sck;
        cs_q_ff <= rst ? 1'b1 : cs_n;
    end
    // Frame bit count and opcode capture
    always_ff @(posedge clk) begin
        if (rst || (cs_n && cs_q_ff)) begin
            bits_ff <= 6'h00;
        end else if (sck_rise && !cs_n && bits_ff != 6'h3F) begin
            bits_ff <= bits_ff + 6'h01;
            if (bits_ff < 6'h08) op_ff <= {op_ff[6:0], si};
        end
    end
    // Busy length expected for the captured opcode
    always_comb begin
        case (op_ff)
            fpec_pkg::OP_PROG_BUF1, fpec_pkg::OP_PROG_BUF2: want = PROG_CYCLES;
            fpec_pkg::OP_PAGE_ERASE: want = PAGE_ERASE_CYCLES;
            fpec_pkg::OP_BLOCK_ERASE: want = BLOCK_ERASE_CYCLES;
            fpec_pkg::OP_SECTOR_ERASE: want = SECTOR_ERASE_CYCLES;
            default: want = 0;
        endcase
    end
    // Cycles spent busy so far
    always_ff @(posedge clk) busy_cnt_ff <= (rst || rdy_busy_n) ? 0 : busy_cnt_ff + 1;
    a_frame_bits: assert property ($rose(cs_n) |-> bits_ff == 6'h20)
        else $error("frame not 32 bits");
    a_cs_fall_clean: assert property ($fell(cs_n) |-> !sck && bits_ff == 6'h00)
        else $error("frame start with clock high");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock moves outside frame");
    a_si_stable: assert property (sck && sck_q_ff |-> $stable(si))
        else $error("data changed while clock high");
    a_launch_busy: assert property ($rose(cs_n) && bits_ff == 6'h20 && want != 0 && rdy_busy_n
        |-> ##[2:6] !rdy_busy_n)
        else $error("valid command did not go busy");
    a_refuse_quiet: assert property ($rose(cs_n) && want == 0 && rdy_busy_n |-> rdy_busy_n [*6])
        else $error("unknown opcode started work");
    a_busy_cause: assert property ($fell(rdy_busy_n) |-> cs_n && $past(cs_n, 3))
        else $error("busy without frame end");
    a_busy_length: assert property ($rose(rdy_busy_n) |-> busy_cnt_ff == want)
        else $error("busy length wrong");
    a_busy_bound: assert property (!rdy_busy_n |-> busy_cnt_ff < want)
        else $error("busy overran");
    c_prog: cover property ($rose(cs_n) && want == PROG_CYCLES);
    c_sector: cover property ($rose(cs_n) && want == SECTOR_ERASE_CYCLES);
    c_ready: cover property ($rose(rdy_busy_n));
endmodule

// ### flash_program_erase_commands_test.sv
module flash_program_erase_commands_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam time D = 2;
    logic clk, rst, ps, cmd_valid, cmd_ready, dev_ready, st_busy, op_start, op_sel, op_0b, op_done, start2;
    fpec_pkg::fpec_op_t op_kind;
    logic [12:0] op_page;
    logic [3:0] op_cnt;
    logic [5:0] op_sec;
    logic [7:0] cmd_op;
    logic [23:0] cmd_addr;
    int bad_count, n_checks, starts2;
    logic ps2, busy2, sel2, sb2, done2;
    fpec_pkg::fpec_op_t kind2;
    logic [12:0] page2;
    logic [3:0] cnt2;
    logic [5:0] sec2;
    fpec_link_if link();
    fpec_link_if link2();
    fpec_host fpec_host_inst(.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_opcode(cmd_op), .cmd_addr(cmd_addr), .dev_ready(dev_ready));
    fpec_device #(.PROG_CYCLES(20), .PAGE_ERASE_CYCLES(30), .BLOCK_ERASE_CYCLES(40), .SECTOR_ERASE_CYCLES(50))
        fpec_device_inst(.clk(clk), .rst(rst), .link(link), .page_size_512(ps), .status_busy(st_busy),
        .op_start(op_start), .op_kind(op_kind), .op_buffer_sel(op_sel), .op_first_page(op_page),
        .op_page_count(op_cnt), .op_sector(op_sec), .op_sector_0b(op_0b), .op_done(op_done));
    // Second device driven by the bench to break framing on purpose
    fpec_device #(.PROG_CYCLES(20), .PAGE_ERASE_CYCLES(600), .BLOCK_ERASE_CYCLES(40), .SECTOR_ERASE_CYCLES(50))
        fpec_device_inst2(.clk(clk), .rst(rst), .link(link2), .page_size_512(ps2), .status_busy(busy2),
        .op_start(start2), .op_kind(kind2), .op_buffer_sel(sel2), .op_first_page(page2), .op_page_count(cnt2),
        .op_sector(sec2), .op_sector_0b(sb2), .op_done(done2));
    fpec_link_properties #(.PROG_CYCLES(20), .PAGE_ERASE_CYCLES(30), .BLOCK_ERASE_CYCLES(40),
        .SECTOR_ERASE_CYCLES(50)) fpec_link_properties_inst(.clk(clk), .rst(rst), .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .rdy_busy_n(link.rdy_busy_n));
    // Clock and launch counter of the second device
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst) starts2 <= 0;
        else if (start2 === 1'b1) starts2 <= starts2 + 1;
    end
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
        #D;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hand one command to the host end
    task send(input logic [7:0] op, input logic [23:0] a, input logic p);
        ps = p;
        cmd_op = op;
        cmd_addr = a;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) tick(1);
        tick(1);
        cmd_valid = 1'b0;
    endtask
    // One command end to end with expected decode
    task run(input logic [7:0] op, input logic [23:0] a, input logic p);
        logic [12:0] pg;
        fpec_pkg::fpec_op_t k;
        int i;
        pg = p ? a[21:9] : a[22:10];
        k = (op == fpec_pkg::OP_PAGE_ERASE) ? fpec_pkg::FPEC_OP_PERASE :
            (op == fpec_pkg::OP_BLOCK_ERASE) ? fpec_pkg::FPEC_OP_BERASE :
            (op == fpec_pkg::OP_SECTOR_ERASE) ? fpec_pkg::FPEC_OP_SERASE : fpec_pkg::FPEC_OP_PROG;
        send(op, a, p);
        for (i = 0; i < 400 && op_start !== 1'b1; i++) tick(1);
        chk("start", 24'({op_start, st_busy, link.rdy_busy_n}), 24'h6);
        chk("kind", 24'(op_kind), 24'(k));
        if (k == fpec_pkg::FPEC_OP_PROG) chk("buffer", 24'(op_sel), 24'(op == fpec_pkg::OP_PROG_BUF2));
        if (k == fpec_pkg::FPEC_OP_SERASE) chk("sector", 24'({op_sec, op_0b}), 24'({pg[12:7], pg[3]}));
        else if (k == fpec_pkg::FPEC_OP_BERASE) chk("block", 24'({op_page, op_cnt}), 24'({pg[12:3], 7'h08}));
        else chk("page", 24'({op_page, op_cnt}), 24'({pg, 4'h1}));
        for (i = 0; i < 400 && op_done !== 1'b1; i++) tick(1);
        chk("done", 24'(op_done), 24'h1);
        tick(3);
        chk("ready", 24'({st_busy, dev_ready, link.rdy_busy_n}), 24'h3);
        $display("test op %h done", op);
    endtask
    // Bit-banged frame of n bits into the second device
    task bb(input int n, input logic [31:0] w);
        int i;
        link2.cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            link2.si = w[31 - i];
            tick(4);
            link2.sck = 1'b1;
            tick(4);
            link2.sck = 1'b0;
        end
        tick(4);
        link2.cs_n = 1'b1;
        link2.si = ~link2.si;
        tick(8);
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        ps = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_addr = 24'h000000;
        bad_count = 0;
        n_checks = 0;
        ps2 = 1'b0;
        link2.cs_n = 1'b1;
        link2.sck = 1'b0;
        link2.si = 1'b0;
        tick(4);
        rst = 1'b0;
        tick(3);
        run(fpec_pkg::OP_PAGE_ERASE, {1'b0, 13'h1ABC, 10'h000}, 1'b0);
        run(fpec_pkg::OP_PROG_BUF1, {1'b1, 13'h1ABC, 10'h3FF}, 1'b0);
        run(fpec_pkg::OP_BLOCK_ERASE, {2'b00, 13'h0552, 9'h000}, 1'b1);
        run(fpec_pkg::OP_PROG_BUF2, {2'b11, 13'h0555, 9'h1FF}, 1'b1);
        run(fpec_pkg::OP_PAGE_ERASE, {1'b1, 13'h1FFF, 10'h000}, 1'b0);
        run(fpec_pkg::OP_PAGE_ERASE, {2'b00, 13'h0001, 9'h1FF}, 1'b1);
        run(fpec_pkg::OP_BLOCK_ERASE, {1'b1, 13'h1FFD, 10'h3FF}, 1'b0);
        run(fpec_pkg::OP_BLOCK_ERASE, {2'b11, 13'h1007, 9'h1FF}, 1'b1);
        run(fpec_pkg::OP_SECTOR_ERASE, {1'b1, 13'h0007, 10'h3FF}, 1'b0);
        run(fpec_pkg::OP_SECTOR_ERASE, {2'b11, 13'h000F, 9'h1FF}, 1'b1);
        run(fpec_pkg::OP_SECTOR_ERASE, {1'b0, 13'h1FC5, 10'h000}, 1'b0);
        run(fpec_pkg::OP_SECTOR_ERASE, {2'b00, 13'h0080, 9'h000}, 1'b1);
        send(8'h83, 24'h000000, 1'b0);
        tick(300);
        chk("unknown", 24'({st_busy, link.rdy_busy_n, op_kind}),
            24'({2'b01, fpec_pkg::FPEC_OP_SERASE}));
        bb(32, {fpec_pkg::OP_PAGE_ERASE, 24'h000000});
        chk("launch2", 24'(starts2), 24'h1);
        chk("erase2", 24'({kind2, page2, cnt2}),
            24'({fpec_pkg::FPEC_OP_PERASE, 13'h0000, 4'h1}));
        bb(32, {fpec_pkg::OP_PAGE_ERASE, 24'h000400});
        chk("busy drop", 24'({page2, 4'(starts2)}), 24'({13'h0000, 4'h1}));
        tick(600);
        bb(31, {fpec_pkg::OP_SECTOR_ERASE, 24'h000000});
        chk("short", 24'(starts2), 24'h1);
        ps2 = 1'b1;
        bb(32, {fpec_pkg::OP_SECTOR_ERASE, 2'b00, 13'h0008, 9'h000});
        chk("launch3", 24'(starts2), 24'h2);
        chk("sector2", 24'({kind2, sec2, sb2, busy2, link2.rdy_busy_n}),
            24'({fpec_pkg::FPEC_OP_SERASE, 6'h00, 1'b1, 2'b10}));
        for (int j = 0; j < 100 && done2 !== 1'b1; j++) tick(1);
        chk("done2", 24'({done2, busy2, link2.rdy_busy_n}), 24'h5);
        ps2 = 1'b0;
        bb(32, {fpec_pkg::OP_PROG_BUF2, 1'b0, 13'h0008, 10'h000});
        chk("launch4", 24'(starts2), 24'h3);
        chk("prog2", 24'({kind2, sel2, page2, cnt2}),
            24'({fpec_pkg::FPEC_OP_PROG, 1'b1, 13'h0008, 4'h1}));
        $display("test refusal done");
        close_out();
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule
